// File: src/light_meas_ctrl.sv
`default_nettype none
module light_meas_ctrl
  import light_pkg::*;
#(
  parameter int W               = light_pkg::DATA_W,
  parameter int WAKE_CYCLES     = light_pkg::WAKE_CYCLES_DEF,
  parameter int AR_RESET_CYCLES = light_pkg::AR_RESET_CYCLES
) (
  input  wire logic         core_clk,            // Core clock, 20 MHz
  input  wire logic         rst,                 // Asynchronous reset, active high
  input  wire logic         mode_wr,             // Operating mode field write strobe
  input  wire logic [1:0]   mode_wdata,          // Operating mode write value
  output logic      [1:0]   mode_field,          // Operating mode field readback
  input  wire logic [3:0]   range_cfg,           // Range field, 0xC is automatic
  input  wire logic         quick_wakeup_bit,    // Stay powered between shots
  input  wire logic         int_dir,             // 1: pin is output, 0: input trigger
  input  wire logic         compare_channel_sel, // Channel for threshold compare
  input  wire logic [W-1:0] thr_low,             // Low threshold
  input  wire logic [W-1:0] thr_high,            // High threshold
  input  wire logic [3:0]   fault_need,          // Consecutive faults needed
  input  wire logic         flag_clr,            // Clear threshold flags
  input  wire logic         int_pin_i,           // Interrupt pin level
  output logic              int_pin_o,           // Interrupt pin drive value
  output logic              int_pin_oe,          // Interrupt pin drive enable
  output logic              analog_on,           // Analog front end powered
  output logic              adc_start,           // Start one conversion
  output logic      [3:0]   adc_range,           // Range for the conversion
  input  wire logic         adc_done,            // Conversion finished
  input  wire logic [W-1:0] adc_ch0,             // Channel 0 raw result
  input  wire logic [W-1:0] adc_ch1,             // Channel 1 raw result
  output logic      [W-1:0] res_ch0,             // Channel 0 output data
  output logic      [W-1:0] res_ch1,             // Channel 1 output data
  output logic      [3:0]   sample_count,        // Output sample counter
  output logic      [3:0]   crc_bits,            // Output CRC bits
  output logic              flag_low,            // Low threshold flag
  output logic              flag_high,           // High threshold flag
  output logic              busy                 // Measurement in progress
);
  import light_pkg::*;

  localparam int WW = $clog2(WAKE_CYCLES + 1);
  localparam int PW = $clog2(INT_PULSE_CYCLES + 1);
  localparam logic [WW-1:0] WAKE_LOAD  = WW'(WAKE_CYCLES);
  localparam logic [PW-1:0] PULSE_LOAD = PW'(INT_PULSE_CYCLES);

  generate
    if (W < 4 || WAKE_CYCLES < 1 || AR_RESET_CYCLES < 1) begin : g_bad
      $error("light_meas_ctrl: W >= 4 and cycle counts >= 1 required");
    end
  endgenerate

  typedef enum logic [2:0] {
    ST_IDLE,    // Standby or power-down
    ST_WAKE,    // Recovering from standby
    ST_AR_RST,  // Waiting for auto-range restart
    ST_START,   // Issue conversion start
    ST_CONV     // Conversion running
  } state_type;

  typedef struct packed {
    state_type     st;        // Sequencer state
    logic [1:0]    mode;      // Operating mode field
    logic          reg_trig;  // Current shot came from a register write
    logic [WW-1:0] wait_cnt;  // Wake countdown
    logic [PW-1:0] pulse;     // Completion pulse countdown
    logic          awake;     // Analog power
    logic          start;     // Conversion start pulse
    logic          restart;   // Auto-range restart pulse
    logic          vld;       // Measurement completed pulse
    logic [W-1:0]  ch0;       // Channel 0 result
    logic [W-1:0]  ch1;       // Channel 1 result
    logic [3:0]    count;     // Sample counter
    logic [3:0]    crc;       // CRC bits
    logic          sync1;     // Pin synchroniser, first stage
    logic          sync2;     // Pin synchroniser, second stage
    logic          sync3;     // Previous synchronised level
  } ctrl_state_type;
  ctrl_state_type s_q, s_d;

  meas_if #(.W(W)) m ();

  // CRC over counter and both results, MSB first
  function automatic logic [3:0] crc4(input logic [3:0] cnt, input logic [W-1:0] a,
                                      input logic [W-1:0] b);
    logic [2*W+3:0] msg;
    logic [3:0]     c;
    logic           fb;
    msg = {cnt, a, b};
    c   = CRC_RESET;
    for (int i = 2 * W + 3; i >= 0; i--) begin
      fb = c[3] ^ msg[i];
      c  = {c[2:0], 1'b0};
      if (fb) begin
        c = c ^ CRC_POLY;
      end
    end
    return c;
  endfunction

  logic pin_fall;   // Falling edge on the synchronised pin
  logic one_shot;   // Mode field holds a one-shot mode
  logic wr_shot;    // Register write requesting a shot
  logic pin_shot;   // Pin trigger accepted
  logic need_ar;    // Shot must restart auto-range
  logic [3:0] cnt_next;  // Counter after this measurement

  assign pin_fall = s_q.sync3 & ~s_q.sync2;
  assign one_shot = (s_q.mode == MODE_SHOT_FORCE) || (s_q.mode == MODE_SHOT_KEEP);
  assign wr_shot  = mode_wr && (mode_wdata == MODE_SHOT_FORCE || mode_wdata == MODE_SHOT_KEEP);
  assign pin_shot = pin_fall && !int_dir && one_shot;
  assign need_ar  = (s_q.mode == MODE_SHOT_FORCE) && (range_cfg == RANGE_AUTO);
  assign cnt_next = s_q.count + 4'h1;

  // Sequencer: mode field, triggers, wake, ranging restart, conversion
  always_comb begin
    s_d         = s_q;
    s_d.sync1   = int_pin_i;
    s_d.sync2   = s_q.sync1;
    s_d.sync3   = s_q.sync2;
    s_d.start   = 1'b0;
    s_d.restart = 1'b0;
    s_d.vld     = 1'b0;
    if (s_q.pulse != '0) begin
      s_d.pulse = s_q.pulse - PW'(1);
    end
    if (mode_wr) begin
      s_d.mode = mode_wdata;  // Host may change mode at any time
    end
    case (s_q.st)
      ST_IDLE: begin
        // A write of mode zero leaves the sequencer asleep
        if (wr_shot || pin_shot || s_q.mode == MODE_CONT) begin
          s_d.reg_trig = wr_shot;
          s_d.st       = ST_WAKE;
          s_d.wait_cnt = s_q.awake ? '0 : WAKE_LOAD;
        end
      end
      ST_WAKE: begin
        if (s_q.wait_cnt != '0) begin
          s_d.wait_cnt = s_q.wait_cnt - WW'(1);
        end else if (need_ar) begin
          s_d.restart = 1'b1;
          s_d.st      = ST_AR_RST;
        end else begin
          s_d.st = ST_START;
        end
      end
      ST_AR_RST: begin
        // Busy rises one cycle after the restart pulse
        if (!s_q.restart && !m.ar_busy) begin
          s_d.st = ST_START;
        end
      end
      ST_START: begin
        s_d.start = 1'b1;
        s_d.st    = ST_CONV;
      end
      ST_CONV: begin
        // New triggers are not looked at here
        if (adc_done) begin
          s_d.ch0   = adc_ch0;
          s_d.ch1   = adc_ch1;
          s_d.count = cnt_next;
          s_d.crc   = crc4(cnt_next, adc_ch0, adc_ch1);
          s_d.vld   = 1'b1;
          if (int_dir) begin
            s_d.pulse = PULSE_LOAD;
          end
          if (s_q.reg_trig && !mode_wr) begin
            s_d.mode = MODE_OFF;
          end
          s_d.reg_trig = 1'b0;
          s_d.st = (s_d.mode == MODE_CONT) ? ST_START : ST_IDLE;
        end
      end
      default: begin
        s_d.st = ST_IDLE;
      end
    endcase
    // Power stays on while busy, in continuous mode, or with quick wake-up in a one-shot mode
    s_d.awake = (s_d.st != ST_IDLE) || (s_d.mode == MODE_CONT) ||
                (quick_wakeup_bit && (s_d.mode == MODE_SHOT_FORCE ||
                                      s_d.mode == MODE_SHOT_KEEP));
  end

  // State register
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_q <= '{st: ST_IDLE, mode: MODE_RESET, reg_trig: 1'b0, wait_cnt: '0, pulse: '0,
               awake: 1'b0, start: 1'b0, restart: 1'b0, vld: 1'b0, ch0: '0, ch1: '0,
               count: COUNT_RESET, crc: CRC_RESET, sync1: 1'b1, sync2: 1'b1, sync3: 1'b1};
    end else begin
      s_q <= s_d;
    end
  end

  // Links to the ranging and threshold blocks
  assign m.ar_restart = s_q.restart;
  assign m.range_cfg  = range_cfg;
  assign m.sample_vld = s_q.vld;
  assign m.ar_sample  = s_q.ch0;
  assign m.cmp_sample = compare_channel_sel ? s_q.ch1 : s_q.ch0;
  assign m.thr_low    = thr_low;
  assign m.thr_high   = thr_high;
  assign m.fault_need = fault_need;
  assign m.flag_clr   = flag_clr;

  auto_range #(.W(W), .RESET_CYCLES(AR_RESET_CYCLES)) u_range (
    .core_clk (core_clk),
    .rst      (rst),
    .m        (m.ranger)
  );

  thresh_fault #(.W(W)) u_fault (
    .core_clk (core_clk),
    .rst      (rst),
    .m        (m.judge)
  );

  // Outputs; the pin is open-drain and pulled low during the pulse
  assign mode_field   = s_q.mode;
  assign int_pin_o    = 1'b0;
  assign int_pin_oe   = int_dir && (s_q.pulse != '0);
  assign analog_on    = s_q.awake;
  assign adc_start    = s_q.start;
  assign adc_range    = m.ar_range;
  assign res_ch0      = s_q.ch0;
  assign res_ch1      = s_q.ch1;
  assign sample_count = s_q.count;
  assign crc_bits     = s_q.crc;
  assign flag_low     = m.flag_low;
  assign flag_high    = m.flag_high;
  assign busy         = s_q.st != ST_IDLE;

  // Checks
  chk_count_wraps: assert property (@(posedge core_clk) disable iff (rst)
    s_q.vld |-> s_q.count == 4'($past(s_q.count) + 4'h1))
    else $error("sample counter did not advance by one");
  chk_crc_fresh: assert property (@(posedge core_clk) disable iff (rst)
    s_q.vld |-> s_q.crc == crc4(s_q.count, s_q.ch0, s_q.ch1))
    else $error("CRC not refreshed with measurement");
  chk_mode_off_quiet: assert property (@(posedge core_clk) disable iff (rst)
    s_q.st == ST_IDLE && s_q.mode == MODE_OFF |-> !analog_on && !adc_start)
    else $error("activity while powered down");
  // Continuous completion with the pin as output both pulses and restarts
  sequence cont_done_seq;
    s_q.vld && int_dir && $past(int_dir) && s_q.mode == MODE_CONT;
  endsequence
  sequence cont_next_seq;
    (int_pin_oe && !adc_start) ##1 adc_start;
  endsequence
  chk_cont_pulse: assert property (@(posedge core_clk) disable iff (rst)
    cont_done_seq |-> cont_next_seq)
    else $error("continuous mode missed pulse or restart");
  sequence force_restart_seq;
    m.ar_restart ##1 m.ar_busy;
  endsequence
  chk_force_restart: assert property (@(posedge core_clk) disable iff (rst)
    s_q.st == ST_WAKE && s_q.wait_cnt == '0 && need_ar |=> force_restart_seq)
    else $error("forced one-shot did not restart auto-range");
  chk_pin_trigger: assert property (@(posedge core_clk) disable iff (rst)
    s_q.st == ST_IDLE && pin_shot && !wr_shot |=> s_q.st == ST_WAKE && !s_q.reg_trig)
    else $error("pin trigger not accepted");
  chk_regtrig_clear: assert property (@(posedge core_clk) disable iff (rst)
    s_q.st == ST_CONV && adc_done && s_q.reg_trig && !mode_wr |=> s_q.mode == MODE_OFF)
    else $error("mode field not cleared after register shot");
  chk_conv_holds: assert property (@(posedge core_clk) disable iff (rst)
    s_q.st == ST_CONV && !adc_done |=> s_q.st == ST_CONV && !adc_start)
    else $error("conversion aborted or restarted");
  chk_pin_in_quiet: assert property (@(posedge core_clk) disable iff (rst)
    s_q.vld && !$past(int_dir) |-> s_q.pulse != PULSE_LOAD)
    else $error("completion pulse started with pin as input");
  sequence shot_done_seq;
    s_q.vld && int_dir && $past(int_dir);
  endsequence
  chk_done_pulse: assert property (@(posedge core_clk) disable iff (rst)
    shot_done_seq |-> int_pin_oe)
    else $error("completion pulse missing");
  chk_quick_power: assert property (@(posedge core_clk) disable iff (rst)
    s_q.st == ST_IDLE && one_shot && $past(quick_wakeup_bit) |-> analog_on)
    else $error("quick wake-up did not keep power on");
endmodule
`default_nettype wire

// File: src/light_pkg.sv
`default_nettype none
package light_pkg;
  localparam int         DATA_W           = 20;          // Result width per channel
  localparam int         CLK_HZ           = 20_000_000;  // Core clock rate
  localparam int         CLK_PER_US       = CLK_HZ / 1_000_000;
  localparam int         AR_RESET_US      = 500;         // Auto-range restart time
  localparam int         AR_RESET_CYCLES  = AR_RESET_US * CLK_PER_US;
  localparam int         INT_PULSE_US     = 1;           // Completion pulse length
  localparam int         INT_PULSE_CYCLES = INT_PULSE_US * CLK_PER_US;
  localparam int         WAKE_CYCLES_DEF  = 20;          // Standby recovery, plain default
  localparam logic [1:0] MODE_OFF         = 2'h0;        // Power-down
  localparam logic [1:0] MODE_SHOT_FORCE  = 2'h1;        // One-shot, restart ranging
  localparam logic [1:0] MODE_SHOT_KEEP   = 2'h2;        // One-shot, keep ranging history
  localparam logic [1:0] MODE_CONT        = 2'h3;        // Continuous
  localparam logic [1:0] MODE_RESET       = MODE_OFF;
  localparam logic [3:0] RANGE_AUTO       = 4'hC;        // Automatic full-scale code
  localparam logic [3:0] RANGE_MAX        = 4'h8;        // Highest fixed range
  localparam logic [3:0] COUNT_RESET      = 4'h0;        // Sample counter at power-up
  localparam logic [3:0] CRC_RESET        = 4'h0;        // CRC seed and reset value
  localparam logic [3:0] CRC_POLY         = 4'h3;        // x^4 + x + 1
endpackage
`default_nettype wire

// File: src/meas_if.sv
`default_nettype none
interface meas_if #(parameter int W = light_pkg::DATA_W);
  logic         ar_restart;  // Restart auto-range from scratch
  logic         ar_busy;     // Auto-range restart still running
  logic [3:0]   ar_range;    // Range for the next conversion
  logic [3:0]   range_cfg;   // Configured range field
  logic         sample_vld;  // One measurement completed
  logic [W-1:0] ar_sample;   // Value used for ranging
  logic [W-1:0] cmp_sample;  // Value used for threshold compare
  logic [W-1:0] thr_low;     // Low threshold
  logic [W-1:0] thr_high;    // High threshold
  logic [3:0]   fault_need;  // Consecutive faults needed
  logic         flag_clr;    // Clear both flags
  logic         flag_low;    // Low threshold flag
  logic         flag_high;   // High threshold flag
  modport ctrl   (output ar_restart, range_cfg, sample_vld, ar_sample, cmp_sample, thr_low,
                  thr_high, fault_need, flag_clr, input ar_busy, ar_range, flag_low, flag_high);
  modport ranger (input ar_restart, range_cfg, sample_vld, ar_sample, output ar_busy, ar_range);
  modport judge  (input sample_vld, cmp_sample, thr_low, thr_high, fault_need, flag_clr,
                  output flag_low, flag_high);
endinterface
`default_nettype wire

// File: src/auto_range.sv
`default_nettype none
module auto_range #(
  parameter int W            = light_pkg::DATA_W,
  parameter int RESET_CYCLES = light_pkg::AR_RESET_CYCLES
) (
  input  wire logic core_clk,  // Core clock
  input  wire logic rst,       // Asynchronous reset
  meas_if.ranger    m          // Ranging signals
);
  import light_pkg::*;
  localparam int CW = $clog2(RESET_CYCLES + 1);
  localparam logic [CW-1:0] LOAD = CW'(RESET_CYCLES - 1);

  typedef struct packed {
    logic [3:0]    range;  // Auto range in use
    logic          busy;   // Restart running
    logic [CW-1:0] cnt;    // Restart countdown
  } ar_state_type;
  ar_state_type r_q, r_d;

  generate
    if (RESET_CYCLES < 1) begin : g_bad
      $error("auto_range: RESET_CYCLES must be at least 1");
    end
  endgenerate

  // Fixed range passes straight through, else the tracked one
  assign m.ar_range = (m.range_cfg == RANGE_AUTO) ? r_q.range : m.range_cfg;
  assign m.ar_busy  = r_q.busy;

  // Restart countdown and per-measurement range stepping
  always_comb begin
    r_d = r_q;
    if (r_q.busy) begin
      if (r_q.cnt == '0) begin
        r_d.busy = 1'b0;
      end else begin
        r_d.cnt = r_q.cnt - CW'(1);
      end
    end
    if (m.ar_restart) begin
      r_d.range = RANGE_MAX;
      r_d.busy  = 1'b1;
      r_d.cnt   = LOAD;
    end else if (m.sample_vld && m.range_cfg == RANGE_AUTO) begin
      if (m.ar_sample[W-1:W-2] != 2'h0 && r_q.range < RANGE_MAX) begin
        r_d.range = r_q.range + 4'h1;  // Near full scale: step up
      end else if (m.ar_sample[W-1:W-4] == 4'h0 && r_q.range >= 4'h2) begin
        r_d.range = r_q.range - 4'h2;  // Far below: step down two
      end else if (m.ar_sample[W-1:W-3] == 3'h0 && r_q.range != 4'h0) begin
        r_d.range = r_q.range - 4'h1;  // Low side: step down one
      end
    end
  end

  // State register
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      r_q <= '{range: RANGE_MAX, busy: 1'b0, cnt: '0};
    end else begin
      r_q <= r_d;
    end
  end

  sequence restart_start_seq;
    m.ar_restart ##1 (r_q.busy && r_q.cnt == LOAD && r_q.range == RANGE_MAX);
  endsequence
  chk_restart_loads_range: assert property (@(posedge core_clk) disable iff (rst)
    m.ar_restart |-> restart_start_seq)
    else $error("auto-range restart did not reload range and countdown");
endmodule
`default_nettype wire

// File: src/thresh_fault.sv
`default_nettype none
module thresh_fault #(
  parameter int W = light_pkg::DATA_W
) (
  input  wire logic core_clk,  // Core clock
  input  wire logic rst,       // Asynchronous reset
  meas_if.judge     m          // Threshold signals
);
  import light_pkg::*;

  typedef struct packed {
    logic [3:0] run;     // Consecutive faults seen
    logic       f_low;   // Low flag
    logic       f_high;  // High flag
  } tf_state_type;
  tf_state_type t_q, t_d;

  logic       is_low;   // Below low threshold
  logic       is_high;  // Above high threshold
  logic [3:0] need;     // Faults needed, zero read as one
  logic [3:0] run_inc;  // Saturating run plus one

  assign is_low       = m.cmp_sample < m.thr_low;
  assign is_high      = m.cmp_sample > m.thr_high;
  assign need         = (m.fault_need == 4'h0) ? 4'h1 : m.fault_need;
  assign run_inc      = (t_q.run == 4'hF) ? 4'hF : t_q.run + 4'h1;
  assign m.flag_low   = t_q.f_low;
  assign m.flag_high  = t_q.f_high;

  // Run counter and flags; a new fault wins over a clear
  always_comb begin
    t_d = t_q;
    if (m.flag_clr) begin
      t_d.f_low  = 1'b0;
      t_d.f_high = 1'b0;
    end
    if (m.sample_vld) begin
      if (is_low || is_high) begin
        t_d.run = run_inc;
        if (run_inc >= need) begin
          t_d.f_low  = t_d.f_low | is_low;
          t_d.f_high = t_d.f_high | is_high;
        end
      end else begin
        t_d.run = 4'h0;  // Streak broken
      end
    end
  end

  // State register
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      t_q <= '{run: 4'h0, f_low: 1'b0, f_high: 1'b0};
    end else begin
      t_q <= t_d;
    end
  end

  chk_flag_after_run: assert property (@(posedge core_clk) disable iff (rst)
    m.sample_vld && is_high && run_inc >= need |=> m.flag_high)
    else $error("high flag not set after enough faults");
  chk_no_early_flag: assert property (@(posedge core_clk) disable iff (rst)
    !t_q.f_low && m.sample_vld && run_inc < need |=> !m.flag_low)
    else $error("low flag set before fault count reached");
endmodule
`default_nettype wire

// File: tb/adc_model.sv
`default_nettype none
module adc_model #(
  parameter int W   = 20,  // Result width
  parameter int LAT = 4    // Conversion cycles
) (
  input  wire logic         core_clk,  // Core clock
  input  wire logic         rst,       // Reset
  input  wire logic         adc_start, // Conversion start
  input  wire logic [W-1:0] v0,        // Light on channel 0
  input  wire logic [W-1:0] v1,        // Light on channel 1
  output logic              adc_done,  // Conversion finished
  output logic      [W-1:0] ch0,       // Channel 0 result
  output logic      [W-1:0] ch1        // Channel 1 result
);
  timeunit 1ns;
  timeprecision 1ns;
  int   cnt;  // Cycles left in conversion
  logic run;  // Conversion running
  // Runs one conversion per start and pulses done once
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      run      <= 1'b0;
      cnt      <= 0;
      adc_done <= 1'b0;
    end else begin
      adc_done <= 1'b0;
      if (adc_start && !run) begin
        run <= 1'b1;
        cnt <= LAT;
      end else if (run && cnt == 0) begin
        run      <= 1'b0;
        adc_done <= 1'b1;
      end else if (run) begin
        cnt <= cnt - 1;
      end
    end
  end
  // Results only hold meaning with done; otherwise inverted
  assign ch0 = adc_done ? v0 : ~v0;
  assign ch1 = adc_done ? v1 : ~v1;
endmodule
`default_nettype wire

// File: tb/tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import light_pkg::*;
  logic              core_clk = 1'b0, rst = 1'b1, mode_wr = 1'b0, int_dir = 1'b1;
  logic              ch_sel = 1'b0, flag_clr = 1'b0, host_low = 1'b0, quick_wakeup_bit = 1'b0;
  logic        [1:0] mode_wdata = 2'h0, mode_field;
  logic        [3:0] range_cfg = 4'h5, fault_need = 4'h2, rng_seen, sample_count, crc_bits;
  logic        [3:0] adc_range;
  logic [DATA_W-1:0] thr_low = 20'h00000, thr_high = 20'hFFFFF, v0 = 20'h01234;
  logic [DATA_W-1:0] v1 = 20'h05678, ch0, ch1, res_ch0, res_ch1;
  logic              adc_start, adc_done, int_pin_o, int_pin_oe, analog_on;
  logic              flag_low, flag_high, busy;
  int                err_total = 0, tests_run = 0, starts = 0, dones = 0, cyc = 0, t0;
  int                oe_cnt = 0;
  // Open-drain pin: pulled high unless the device or host pulls it low
  wire logic         pin_w = ~(int_pin_oe | host_low);
  always #25 core_clk = ~core_clk;
  light_meas_ctrl #(.W(DATA_W), .WAKE_CYCLES(3), .AR_RESET_CYCLES(20)) uut (
    .core_clk(core_clk), .rst(rst), .mode_wr(mode_wr), .mode_wdata(mode_wdata),
    .mode_field(mode_field), .range_cfg(range_cfg), .quick_wakeup_bit(quick_wakeup_bit),
    .int_dir(int_dir), .compare_channel_sel(ch_sel), .thr_low(thr_low), .thr_high(thr_high),
    .fault_need(fault_need), .flag_clr(flag_clr), .int_pin_i(pin_w), .int_pin_o(int_pin_o),
    .int_pin_oe(int_pin_oe), .analog_on(analog_on), .adc_start(adc_start),
    .adc_range(adc_range), .adc_done(adc_done), .adc_ch0(ch0), .adc_ch1(ch1),
    .res_ch0(res_ch0), .res_ch1(res_ch1), .sample_count(sample_count), .crc_bits(crc_bits),
    .flag_low(flag_low), .flag_high(flag_high), .busy(busy));
  adc_model #(.W(DATA_W)) adc (.core_clk(core_clk), .rst(rst), .adc_start(adc_start),
    .v0(v0), .v1(v1), .adc_done(adc_done), .ch0(ch0), .ch1(ch1));
  // Logs starts, completions, chosen range and pin pulses
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (adc_start === 1'b1) begin
      starts   <= starts + 1;
      t0       <= cyc;
      rng_seen <= adc_range;
    end
    if (adc_done === 1'b1) dones <= dones + 1;
    if (int_pin_oe === 1'b1) oe_cnt <= oe_cnt + 1;
  end
  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic logic [3:0] crc(input logic [43:0] d);
    logic [3:0] c;
    c = CRC_RESET;
    for (int i = 43; i >= 0; i--) c = {c[2:0], 1'b0} ^ ((c[3] ^ d[i]) ? CRC_POLY : 4'h0);
    return c;
  endfunction
  task automatic go(input logic [1:0] m);
    @(posedge core_clk);
    mode_wr    <= 1'b1;
    mode_wdata <= m;
    @(posedge core_clk);
    mode_wr <= 1'b0;
    #1;
  endtask
  task automatic idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 2000) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk("busy", 0, busy);
    @(posedge core_clk);
    #1;
  endtask
  task automatic pin_fall();
    @(posedge core_clk);
    host_low <= 1'b1;
    repeat (4) @(posedge core_clk);
    host_low <= 1'b0;
    repeat (4) @(posedge core_clk);
    #1;
  endtask
  task automatic t_shot();
    chk("mode_field", 0, mode_field);
    chk("sample_count", 0, sample_count);
    go(MODE_SHOT_KEEP);
    idle();
    chk("sample_count", 1, sample_count);
    chk("crc_bits", crc({4'h1, v0, v1}), crc_bits);
    chk("mode_field", 0, mode_field);
    chk("res_ch1", v1, res_ch1);
    chk("int_pin_oe", 1, int_pin_oe);
    chk("int_pin_o", 0, int_pin_o);
    chk("analog_on", 0, analog_on);
    chk("fixed range", 5, rng_seen);
  endtask
  task automatic t_ignore();
    int s;
    s = starts;
    go(MODE_SHOT_KEEP);
    repeat (2) @(posedge core_clk);
    go(MODE_SHOT_FORCE);
    idle();
    repeat (10) @(posedge core_clk);
    chk("starts", s + 1, starts);
    chk("sample_count", 2, sample_count);
  endtask
  task automatic t_thresh();
    ch_sel   <= 1'b1;
    v0       <= 20'hFFFFF;
    v1       <= 20'h00100;
    thr_low  <= 20'h00200;
    thr_high <= 20'h80000;
    go(MODE_SHOT_KEEP);
    idle();
    chk("flag_low", 0, flag_low);
    go(MODE_SHOT_KEEP);
    idle();
    chk("flag_low", 1, flag_low);
    chk("flag_high", 0, flag_high);
    flag_clr <= 1'b1;
    @(posedge core_clk);
    flag_clr <= 1'b0;
    @(posedge core_clk);
    #1;
    chk("flag_low", 0, flag_low);
    ch_sel <= 1'b0;
    go(MODE_SHOT_KEEP);
    idle();
    chk("flag_high", 1, flag_high);
    chk("flag_low", 0, flag_low);
  endtask
  task automatic t_auto();
    int s;
    range_cfg <= RANGE_AUTO;
    v0        <= 20'h00100;
    go(MODE_SHOT_FORCE);
    s = cyc;
    idle();
    chk("restart range", 8, rng_seen);
    chk("restart wait", 1, (t0 - s) >= 20);
    go(MODE_SHOT_KEEP);
    idle();
    chk("kept range", 6, rng_seen);
    go(MODE_SHOT_FORCE);
    idle();
    chk("restart range", 8, rng_seen);
  endtask
  task automatic t_cont();
    int n, d, o;
    logic [3:0] c0;
    repeat (25) @(posedge core_clk);
    #1;
    c0 = sample_count;
    d  = dones;
    o  = oe_cnt;
    go(MODE_CONT);
    for (int i = 1; i <= 16; i++) begin
      n = 0;
      while (dones < d + i && n < 200) begin
        @(posedge core_clk);
        #1;
        n++;
      end
      @(posedge core_clk);
      #1;
      chk("sample_count", 4'(c0 + 4'(i)), sample_count);
    end
    chk("cont pulse", 1, oe_cnt > o);
    go(MODE_SHOT_KEEP);
    idle();
  endtask
  task automatic t_pin();
    int d, o, s;
    int_dir          <= 1'b0;
    quick_wakeup_bit <= 1'b1;
    o = oe_cnt;
    d = dones;
    s = cyc;
    pin_fall();
    repeat (30) @(posedge core_clk);
    #1;
    chk("res_ch0", v0, res_ch0);
    idle();
    chk("pin shot", d + 1, dones);
    chk("no pulse", o, oe_cnt);
    chk("quick wake", 6, t0 - s);
    chk("analog_on", 1, analog_on);
    chk("mode_field", 2, mode_field);
    go(MODE_OFF);
    pin_fall();
    repeat (30) @(posedge core_clk);
    #1;
    chk("off shot", d + 1, dones);
    chk("analog_on", 0, analog_on);
  endtask
  task automatic final_report();
    if (err_total == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Cuts a hang short
  initial begin
    repeat (20000) @(posedge core_clk);
    err_total++;
    final_report();
  end
  initial begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    #1;
    t_shot();
    t_ignore();
    t_thresh();
    t_auto();
    t_cont();
    t_pin();
    final_report();
  end
endmodule
`default_nettype wire
